/* File: design/vca_core.sv */
// colour adjust stage: luma gain, u/v gains and subcarrier hue offset,
// with the byte registers that steer them
// assumes the upstream datapath and host port run on clk_in; samples are
// 8-bit y and offset-binary u/v (128 = no colour)
`timescale 1ns/1ps
`include "vca_params.svh"

module vca_core
	import vca_pkg::*;
#(
	parameter int PHASE_W = `VCA_PHASE_W,
	parameter int FIFO_DEPTH = `VCA_FIFO_DEPTH
) (
	input wire logic clk_in, // pixel clock
	input wire logic rst_in, // async reset, high
	input wire logic [7:0] reg_addr_in, // register offset
	input wire logic reg_wr_in, // write strobe
	input wire logic reg_rd_in, // read strobe
	input wire vca_pkg::vca_byte_type reg_wdata_in, // write data
	output vca_pkg::vca_byte_type reg_rdata_out, // read data, next cycle
	input wire logic pix_valid_in, // input sample valid
	output logic pix_ready_out, // input sample taken
	input wire vca_pkg::vca_byte_type pix_y_in, // luma sample
	input wire vca_pkg::vca_byte_type pix_u_in, // u sample
	input wire vca_pkg::vca_byte_type pix_v_in, // v sample
	input wire logic [PHASE_W-1:0] phase_in, // raw subcarrier phase
	output logic [PHASE_W-1:0] phase_out, // phase plus hue offset
	output logic out_valid_out, // adjusted sample valid
	input wire logic out_ready_in, // downstream takes sample
	output vca_pkg::vca_byte_type out_y_out, // adjusted luma
	output vca_pkg::vca_byte_type out_u_out, // adjusted u
	output vca_pkg::vca_byte_type out_v_out // adjusted v
);
	localparam int HUE_SHIFT = PHASE_W - `VCA_HUE_STEP_BITS;

	typedef struct packed {
		vca_regs_type regs;
		vca_byte_type rdata;
		logic stage_valid;
		vca_pix_type stage_pix;
		logic [PHASE_W-1:0] phase;
	} vca_core_state_type;

	vca_core_state_type q;
	vca_core_state_type n;

	vca_gain_type luma_gain;
	vca_gain_type u_gain;
	vca_gain_type v_gain;
	logic [PHASE_W-1:0] hue_ext;
	logic [PHASE_W-1:0] hue_offset;
	vca_pix_type adj_pix;
	vca_pix_type fifo_pix;
	logic fifo_wr_ready;
	logic take_pix;

	// luma: unsigned product, clipped at full scale
	function automatic vca_byte_type luma_scale(
		input vca_byte_type y,
		input vca_gain_type g
	);
		logic [16:0] prod;
		logic [16:0] quo;
		prod = {9'h000, y} * {8'h00, g};
		quo = prod / {8'h00, `VCA_Y_UNITY};
		if (quo > 17'h000ff) begin
			luma_scale = 8'hff;
		end else begin
			luma_scale = quo[7:0];
		end
	endfunction : luma_scale

	// chroma: scale the signed swing around 128 so that zero colour stays put
	function automatic vca_byte_type chroma_scale(
		input vca_byte_type c,
		input vca_gain_type g,
		input logic [9:0] unity
	);
		logic signed [8:0] swing;
		logic signed [18:0] prod;
		logic signed [18:0] quo;
		swing = $signed({1'b0, c}) - 9'sh080;
		prod = swing * $signed({1'b0, g});
		quo = prod / $signed({9'h000, unity});
		if (quo > 19'sh0007f) begin
			chroma_scale = 8'hff;
		end else if (quo < -19'sh00080) begin
			chroma_scale = 8'h00;
		end else begin
			chroma_scale = quo[7:0] ^ 8'h80;
		end
	endfunction : chroma_scale

	// gains follow register writes on the very next sample; a mid-line
	// change is allowed and simply shows from that pixel on
	assign luma_gain = {q.regs.misc[`VCA_BIT_LUMA_TOP], q.regs.luma_gain_low};
	assign u_gain = {q.regs.misc[`VCA_BIT_U_TOP], q.regs.u_gain_low};
	assign v_gain = {q.regs.misc[`VCA_BIT_V_TOP], q.regs.v_gain_low};

	always_comb begin
		adj_pix.y = luma_scale(pix_y_in, luma_gain);
		adj_pix.u = chroma_scale(pix_u_in, u_gain, `VCA_U_UNITY);
		adj_pix.v = chroma_scale(pix_v_in, v_gain, `VCA_V_UNITY);
	end

	// hue byte is sign extended, then lifted so its lsb is 1/512 turn
	assign hue_ext = {{(PHASE_W-8){q.regs.hue_phase_offset[7]}}, q.regs.hue_phase_offset};
	assign hue_offset = hue_ext << HUE_SHIFT;

	// one output stage in front of the fifo; it stalls only when the
	// fifo is full, so back-pressure reaches the upstream datapath
	assign pix_ready_out = !q.stage_valid || fifo_wr_ready;
	assign take_pix = pix_valid_in && pix_ready_out;

	always_comb begin
		n = q;

		// register writes: every mapped offset open at all times, unmapped offsets ignored
		if (reg_wr_in) begin
			case (reg_addr_in)
				`VCA_OFS_MISC: begin
					n.regs.misc = reg_wdata_in;
				end
				`VCA_OFS_LUMA: begin
					n.regs.luma_gain_low = reg_wdata_in;
				end
				`VCA_OFS_U_GAIN: begin
					n.regs.u_gain_low = reg_wdata_in;
				end
				`VCA_OFS_V_GAIN: begin
					n.regs.v_gain_low = reg_wdata_in;
				end
				`VCA_OFS_HUE: begin
					n.regs.hue_phase_offset = reg_wdata_in;
				end
				`VCA_OFS_RSV_A: begin
					n.regs.reserved_a = reg_wdata_in;
				end
				`VCA_OFS_RSV_B: begin
					n.regs.reserved_b = reg_wdata_in;
				end
				default: begin
					n.regs = q.regs;
				end
			endcase
		end

		// reads return the value held before a same-cycle write
		if (reg_rd_in) begin
			case (reg_addr_in)
				`VCA_OFS_MISC: begin
					n.rdata = q.regs.misc;
				end
				`VCA_OFS_LUMA: begin
					n.rdata = q.regs.luma_gain_low;
				end
				`VCA_OFS_U_GAIN: begin
					n.rdata = q.regs.u_gain_low;
				end
				`VCA_OFS_V_GAIN: begin
					n.rdata = q.regs.v_gain_low;
				end
				`VCA_OFS_HUE: begin
					n.rdata = q.regs.hue_phase_offset;
				end
				`VCA_OFS_RSV_A: begin
					n.rdata = q.regs.reserved_a;
				end
				`VCA_OFS_RSV_B: begin
					n.rdata = q.regs.reserved_b;
				end
				default: begin
					n.rdata = `VCA_RD_UNMAPPED;
				end
			endcase
		end

		// sample stage
		if (take_pix) begin
			n.stage_valid = 1'b1;
			n.stage_pix = adj_pix;
		end else if (fifo_wr_ready) begin
			n.stage_valid = 1'b0;
		end

		// phase path runs every clock; the demodulator samples it freely
		n.phase = PHASE_W'(phase_in + hue_offset);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			q.regs.misc <= `VCA_RST_MISC;
			q.regs.luma_gain_low <= `VCA_RST_LUMA;
			q.regs.u_gain_low <= `VCA_RST_U_GAIN;
			q.regs.v_gain_low <= `VCA_RST_V_GAIN;
			q.regs.hue_phase_offset <= `VCA_RST_HUE;
			q.regs.reserved_a <= `VCA_RST_RSV;
			q.regs.reserved_b <= `VCA_RST_RSV;
			q.rdata <= '0;
			q.stage_valid <= 1'b0;
			q.stage_pix <= '0;
			q.phase <= '0;
		end else begin
			q <= n;
		end
	end

	// the fifo absorbs short downstream stalls so the datapath keeps pace
	vca_fifo #(
		.WIDTH($bits(vca_pix_type)),
		.DEPTH(FIFO_DEPTH)
	) u_out_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_valid_in(q.stage_valid),
		.wr_ready_out(fifo_wr_ready),
		.wr_data_in(q.stage_pix),
		.rd_valid_out(out_valid_out),
		.rd_ready_in(out_ready_in),
		.rd_data_out(fifo_pix)
	);

	assign out_y_out = fifo_pix.y;
	assign out_u_out = fifo_pix.u;
	assign out_v_out = fifo_pix.v;
	assign reg_rdata_out = q.rdata;
	assign phase_out = q.phase;
endmodule : vca_core

/* File: design/vca_fifo.sv */
// flop based fifo with valid/ready on both sides
// assumes one clock; DEPTH need not be a power of two
`timescale 1ns/1ps
module vca_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic clk_in, // clock
	input wire logic rst_in, // async reset, high
	input wire logic wr_valid_in, // push request
	output logic wr_ready_out, // not full
	input wire logic [WIDTH-1:0] wr_data_in, // push data
	output logic rd_valid_out, // not empty
	input wire logic rd_ready_in, // pop request
	output logic [WIDTH-1:0] rd_data_out // head word, from flops
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_idx;
		logic [AW-1:0] rd_idx;
		logic [CW-1:0] count;
	} vca_fifo_state_type;

	vca_fifo_state_type q;
	vca_fifo_state_type n;
	logic push;
	logic pop;

	assign wr_ready_out = (q.count != CW'(DEPTH));
	assign rd_valid_out = (q.count != '0);
	assign rd_data_out = q.mem[q.rd_idx];
	assign push = wr_valid_in && wr_ready_out;
	assign pop = rd_valid_out && rd_ready_in;

	always_comb begin
		n = q;
		if (push) begin
			n.mem[q.wr_idx] = wr_data_in;
			n.wr_idx = (q.wr_idx == AW'(DEPTH - 1)) ? '0 : AW'(q.wr_idx + 1'b1);
		end
		if (pop) begin
			n.rd_idx = (q.rd_idx == AW'(DEPTH - 1)) ? '0 : AW'(q.rd_idx + 1'b1);
		end
		if (push && !pop) begin
			n.count = CW'(q.count + 1'b1);
		end else if (pop && !push) begin
			n.count = CW'(q.count - 1'b1);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule : vca_fifo

/* File: pkg/vca_params.svh */
// constants of the colour adjust stage: register offsets, reset values,
// field positions and the unity divisors of the gain multipliers
// assumes an 8-bit register address space shared with the rest of the decoder
`ifndef VCA_PARAMS_SVH
`define VCA_PARAMS_SVH

`define VCA_OFS_MISC 8'h0b
`define VCA_OFS_LUMA 8'h0c
`define VCA_OFS_U_GAIN 8'h0d
`define VCA_OFS_V_GAIN 8'h0e
`define VCA_OFS_HUE 8'h0f
`define VCA_OFS_RSV_A 8'h10
`define VCA_OFS_RSV_B 8'h11

`define VCA_RST_MISC 8'h20
`define VCA_RST_LUMA 8'hd8
`define VCA_RST_U_GAIN 8'hfe
`define VCA_RST_V_GAIN 8'hb4
`define VCA_RST_HUE 8'h00
`define VCA_RST_RSV 8'h00
`define VCA_RD_UNMAPPED 8'h00

`define VCA_BIT_LUMA_TOP 2
`define VCA_BIT_U_TOP 1
`define VCA_BIT_V_TOP 0

`define VCA_Y_UNITY 9'd216
`define VCA_U_UNITY 10'd254
`define VCA_V_UNITY 10'd180

// one hue lsb is 1/512 of a full subcarrier turn, about 0.7 degrees
`define VCA_HUE_STEP_BITS 9
`define VCA_PHASE_W 16
`define VCA_FIFO_DEPTH 16

`endif

/* File: pkg/vca_pkg.sv */
// types of the colour adjust stage
// assumes vca_params.svh supplies the numbers
package vca_pkg;
	typedef logic [8:0] vca_gain_type;
	typedef logic [7:0] vca_byte_type;

	typedef struct packed {
		vca_byte_type misc;
		vca_byte_type luma_gain_low;
		vca_byte_type u_gain_low;
		vca_byte_type v_gain_low;
		vca_byte_type hue_phase_offset;
		vca_byte_type reserved_a;
		vca_byte_type reserved_b;
	} vca_regs_type;

	typedef struct packed {
		vca_byte_type y;
		vca_byte_type u;
		vca_byte_type v;
	} vca_pix_type;
endpackage : vca_pkg

/* File: verification/vca_core_properties.sv */
// port checker for the colour adjust stage
// assumes one clock, offsets from vca_params.svh, hue lsb at bit PHASE_W-9
`timescale 1ns/1ps
`include "vca_params.svh"
module vca_core_properties
	import vca_pkg::*;
#(
	parameter int PHASE_W = 16
) (
	input wire logic clk_in, // clock
	input wire logic rst_in, // reset
	input wire logic [7:0] reg_addr_in, // offset
	input wire logic reg_wr_in, // write
	input wire logic reg_rd_in, // read
	input wire vca_pkg::vca_byte_type reg_wdata_in, // wdata
	input wire vca_pkg::vca_byte_type reg_rdata_out, // rdata
	input wire logic [PHASE_W-1:0] phase_in, // phase in
	input wire logic [PHASE_W-1:0] phase_out, // phase out
	input wire logic pix_valid_in, // in valid
	input wire logic pix_ready_out, // in ready
	input wire logic out_valid_out, // out valid
	input wire logic out_ready_in, // out ready
	input wire vca_pkg::vca_byte_type out_y_out // out luma
);
	// shadow of the hue byte, so the phase sum can be checked from ports alone
	vca_byte_type hue_q;
	logic [PHASE_W-1:0] ofs;
	assign ofs = {{(PHASE_W-8){hue_q[7]}}, hue_q} << (PHASE_W-9);
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) hue_q <= 8'h00;
		else if (reg_wr_in && reg_addr_in == `VCA_OFS_HUE) hue_q <= reg_wdata_in;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	rd_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved");
	hue_read_a: assert property (reg_rd_in && reg_addr_in == `VCA_OFS_HUE |=> reg_rdata_out == $past(hue_q))
		else $error("hue readback wrong");
	unmap_read_a: assert property (reg_rd_in && reg_addr_in > `VCA_OFS_RSV_B |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	phase_sum_a: assert property (!$past(rst_in) |-> phase_out == $past(phase_in) + $past(ofs))
		else $error("phase offset wrong");
	first_out_a: assert property (pix_valid_in && pix_ready_out && !out_valid_out |-> ##[1:2] out_valid_out)
		else $error("sample late");
	out_hold_a: assert property (out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_y_out))
		else $error("head dropped");
	full_ready_a: assert property (!pix_ready_out |-> out_valid_out)
		else $error("refused while empty");
	empty_ready_a: assert property (!out_valid_out |-> pix_ready_out)
		else $error("not ready while empty");
	cover property (!pix_ready_out);
	cover property (reg_rd_in && reg_addr_in == `VCA_OFS_HUE);
	cover property (out_valid_out && out_ready_in);
endmodule : vca_core_properties

bind vca_core vca_core_properties #(.PHASE_W(PHASE_W)) u_props (.clk_in, .rst_in, .reg_addr_in, .reg_wr_in,
	.reg_rd_in, .reg_wdata_in, .reg_rdata_out, .phase_in, .phase_out, .pix_valid_in, .pix_ready_out,
	.out_valid_out, .out_ready_in, .out_y_out);

/* File: verification/vca_core_test.sv */
// self-checking bench of the colour adjust stage
// assumes vca_core with default parameters and the sink model
`timescale 1ns/1ps
`include "vca_params.svh"
module vca_core_test;
	import vca_pkg::*;
	logic clk_in = '0, rst_in = '1, reg_wr_in = '0, reg_rd_in = '0, pix_valid_in = '0;
	logic pix_ready_out, out_valid_out, out_ready_in;
	vca_byte_type reg_addr_in = '0, reg_wdata_in = '0, pix_y_in = '0, pix_u_in = '0, pix_v_in = '0;
	vca_byte_type reg_rdata_out, out_y_out, out_u_out, out_v_out, misc = `VCA_RST_MISC;
	logic [15:0] phase_in = '0, phase_out, ph;
	vca_byte_type hue;
	logic [1:0] mode = 2'h1;
	vca_gain_type gy = `VCA_Y_UNITY, gu = 9'h0fe, gv = 9'h0b4, g;
	int n_errors = 0, checked = 0;
	logic [23:0] expq[$];
	vca_core uut (.clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
		.pix_valid_in, .pix_ready_out, .pix_y_in, .pix_u_in, .pix_v_in, .phase_in, .phase_out,
		.out_valid_out, .out_ready_in, .out_y_out, .out_u_out, .out_v_out);
	vca_sink u_sink (.clk_in, .mode_in(mode), .ready_out(out_ready_in));
	always #5 clk_in = ~clk_in;
	always @(negedge clk_in) phase_in = 16'($urandom);
	function automatic vca_byte_type fy(int y, int g, int d);
		return y * g / d > 255 ? 8'hff : 8'(y * g / d);
	endfunction : fy
	function automatic vca_byte_type fc(int c, int g, int d);
		int q = (c - 128) * g / d;
		q = q > 127 ? 127 : q < -128 ? -128 : q;
		return 8'(q + 128);
	endfunction : fc
	task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic wait_ok(int w);
		if (w < 2000) return;
		check("wait", 1, 0);
		end_of_test();
	endtask : wait_ok
	task automatic wr(vca_byte_type a, vca_byte_type d);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = '1;
		@(negedge clk_in);
		reg_wr_in = '0;
	endtask : wr
	task automatic rdc(vca_byte_type a, vca_byte_type e);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_rd_in = '1;
		@(negedge clk_in);
		reg_rd_in = '0;
		check("reg", reg_rdata_out, e);
	endtask : rdc
	task automatic push(int n);
		int w;
		@(negedge clk_in);
		repeat (n) begin
			pix_valid_in = '1;
			{pix_y_in, pix_u_in, pix_v_in} = $urandom_range(3) ? 24'($urandom) : 24'hff00ff;
			for (w = 0; !pix_ready_out && w < 2000; w++) @(negedge clk_in);
			wait_ok(w);
			@(negedge clk_in);
		end
		pix_valid_in = '0;
	endtask : push
	task automatic drain();
		int w;
		for (w = 0; expq.size() > 0 && w < 2000; w++) @(negedge clk_in);
		wait_ok(w);
	endtask : drain
	task automatic gains(vca_gain_type y, vca_gain_type u, vca_gain_type v);
		gy = y;
		gu = u;
		gv = v;
		wr(`VCA_OFS_LUMA, y[7:0]);
		wr(`VCA_OFS_U_GAIN, u[7:0]);
		wr(`VCA_OFS_V_GAIN, v[7:0]);
		rdc(`VCA_OFS_MISC, misc);
		misc = {misc[7:3], y[8], u[8], v[8]};
		wr(`VCA_OFS_MISC, misc);
	endtask : gains
	always @(posedge clk_in) begin
		if (!rst_in && pix_valid_in && pix_ready_out)
			expq.push_back({fy(pix_y_in, gy, `VCA_Y_UNITY), fc(pix_u_in, gu, `VCA_U_UNITY), fc(pix_v_in, gv, `VCA_V_UNITY)});
		if (!rst_in && out_valid_out && out_ready_in)
			check("pix", {out_y_out, out_u_out, out_v_out}, expq.pop_front());
	end
	initial begin
		void'($urandom(32'h1455536b));
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = '0;
		rdc(`VCA_OFS_LUMA, `VCA_RST_LUMA);
		rdc(`VCA_OFS_U_GAIN, `VCA_RST_U_GAIN);
		rdc(`VCA_OFS_V_GAIN, `VCA_RST_V_GAIN);
		rdc(`VCA_OFS_HUE, `VCA_RST_HUE);
		rdc(`VCA_OFS_RSV_A, `VCA_RST_RSV);
		rdc(`VCA_OFS_RSV_B, `VCA_RST_RSV);
		wr(8'h40, 8'h5a);
		rdc(8'h40, `VCA_RD_UNMAPPED);
		wr(`VCA_OFS_RSV_A, 8'h00);
		wr(`VCA_OFS_RSV_B, 8'h00);
		push(20);
		drain();
		for (int i = 0; i < 10; i++) begin
			// even passes let the sink take every word, odd ones stall at random
			mode = 2'(i % 2);
			g = i < 2 ? 9'(i * 511) : 9'($urandom);
			gains(i == 2 ? 9'd217 : g, g, 9'(g * 180 / 254));
			hue = i < 2 ? 8'h80 - 8'(i) : 8'($urandom);
			fork
				push(40);
				begin
					wr(`VCA_OFS_HUE, hue);
					rdc(`VCA_OFS_HUE, hue);
				end
			join
			drain();
		end
		// most negative hue byte turns the subcarrier back by a quarter turn
		wr(`VCA_OFS_HUE, 8'h80);
		@(posedge clk_in);
		ph = phase_in;
		@(negedge clk_in);
		check("phase", phase_out, 16'(ph - 16'h4000));
		// reset in mid-run must bring every changed setting back
		@(negedge clk_in);
		rst_in = '1;
		repeat (2) @(negedge clk_in);
		rst_in = '0;
		misc = `VCA_RST_MISC;
		gy = `VCA_Y_UNITY;
		gu = 9'h0fe;
		gv = 9'h0b4;
		rdc(`VCA_OFS_MISC, misc);
		rdc(`VCA_OFS_LUMA, `VCA_RST_LUMA);
		rdc(`VCA_OFS_U_GAIN, `VCA_RST_U_GAIN);
		rdc(`VCA_OFS_V_GAIN, `VCA_RST_V_GAIN);
		rdc(`VCA_OFS_HUE, `VCA_RST_HUE);
		mode = 2'h2;
		push(17);
		check("full", pix_ready_out, 0);
		mode = 2'h1;
		drain();
		end_of_test();
	end
endmodule : vca_core_test

/* File: verification/vca_sink.sv */
// downstream formatter model: pops adjusted samples
// assumes the bench picks the stall mode
`timescale 1ns/1ps
module vca_sink (
	input wire logic clk_in, // clock
	input wire logic [1:0] mode_in, // 0 take, 1 random, 2 stall
	output logic ready_out // pop
);
	initial ready_out = '0;
	// moves off the rising edge so a pop never races the fifo update
	always @(negedge clk_in) begin
		ready_out <= mode_in == 2'h0 || (mode_in == 2'h1 && $urandom_range(1));
	end
endmodule : vca_sink
